/* File: src/urt_defs.svh */
`ifndef URT_DEFS_SVH
`define URT_DEFS_SVH
// clock and top baud rate
`define URT_CLK_HZ 25000000
`define URT_MAX_BAUD 1000000
// smallest divider allowed: one bit of the fastest rate
`define URT_MIN_DIV (`URT_CLK_HZ / `URT_MAX_BAUD)
`define URT_DIV_RST 16'h00d9
// receive buffer depth in characters
`define URT_RX_DEPTH 6
// free slots at which request-to-send is withdrawn
`define URT_RTS_MARGIN 3'h2
`define URT_BITS 4'h8
`endif

/* File: src/urt_pkg.sv */
package urt_pkg;
  // one character with its receive status
  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } urt_char_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } urt_state_e;
endpackage : urt_pkg

/* File: src/urt_core.sv */
`timescale 1ns/1ps
`include "urt_defs.svh"
// Function
// - full-duplex serial port with flow control at up to 1 Mbps.
// - with parity on, a ninth bit is sent and checked.
// - request-to-send is driven out and clear-to-send sampled in.
// - both handshake lines are active low.
// - data lines rest high when no character is sent.
// - a handshake line at 0 V counts as asserted.
// - the far side's transmit feeds our input, ours feeds its receive.
// - the transmit line is an output held high while idle.
// - the receive pin is pulled up so an open line reads idle.
// - after reset request-to-send is driven low to accept data.
// - clear-to-send is pulled down so an open line permits sending.
// - received characters are held in a six-character buffer.
// - framing and handshake follow the usual industry convention.
module urt_core
  import urt_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // configuration
  input wire logic [15:0] i_baud_div,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  // serial pins
  input wire logic i_rx,
  output logic o_tx,
  output logic o_rx_pullup,
  input wire logic i_cts_n,
  output logic o_cts_pulldown,
  output logic o_rts_n,
  // user transmit side
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // user receive side
  output logic o_rx_valid,
  output urt_char_s o_rx_char,
  input wire logic i_rx_ready
);
  // parity of a byte, used by both directions
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction : par_of
  // divider clamped so the rate never exceeds the top rate
  logic [15:0] div;
  assign div = (i_baud_div < 16'(`URT_MIN_DIV)) ? 16'(`URT_MIN_DIV)
                                                : i_baud_div;
  // static pad controls: pull-up on receive, pull-down on clear-to-send
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_pullup <= 1'b1;
      o_cts_pulldown <= 1'b1;
    end else begin
      o_rx_pullup <= 1'b1;
      o_cts_pulldown <= 1'b1;
    end
  end
  // input synchronisers; first stage feeds only the second
  logic rx_s1_ff, rx_s2_ff, cts_s1_ff, cts_s2_ff, cts_on;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      cts_s1_ff <= 1'b1;
      cts_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= i_rx;
      rx_s2_ff <= rx_s1_ff;
      cts_s1_ff <= i_cts_n;
      cts_s2_ff <= cts_s1_ff;
    end
  end
  assign cts_on = ~cts_s2_ff; // low level means asserted
  // ---- transmit: two-entry skid buffer in front of the shifter
  logic [7:0] tb_mem [0:1];
  logic tb_wp_ff, tb_rp_ff;
  logic [1:0] tb_cnt_ff;
  logic tx_take, tb_push, tx_par_ff, tx_tick;
  urt_state_e tx_st_ff;
  logic [15:0] tx_div_ff;
  logic [3:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  assign tb_push = i_tx_valid & o_tx_ready;
  // a new character leaves only with clear-to-send asserted
  assign tx_take = (tx_st_ff == ST_IDLE) && (tb_cnt_ff != 2'h0)
                   && cts_on;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tb_wp_ff <= 1'b0;
      tb_rp_ff <= 1'b0;
      tb_cnt_ff <= 2'h0;
      o_tx_ready <= 1'b1;
    end else begin
      if (tb_push) begin
        tb_mem[tb_wp_ff] <= i_tx_data;
        tb_wp_ff <= ~tb_wp_ff;
      end
      if (tx_take) begin
        tb_rp_ff <= ~tb_rp_ff;
      end
      tb_cnt_ff <= tb_cnt_ff + {1'b0, tb_push} - {1'b0, tx_take};
      o_tx_ready <= (tb_cnt_ff + {1'b0, tb_push} - {1'b0, tx_take})
                    != 2'h2;
    end
  end
  // transmit bit engine
  assign tx_tick = (tx_div_ff == 16'h0000);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_st_ff <= ST_IDLE;
      tx_div_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      o_tx <= 1'b1;
    end else begin
      tx_div_ff <= tx_tick ? div - 16'h0001 : tx_div_ff - 16'h0001;
      case (tx_st_ff)
        ST_IDLE: begin
          o_tx <= 1'b1; // idle high
          if (tx_take) begin
            tx_sh_ff <= tb_mem[tb_rp_ff];
            tx_par_ff <= par_of(tb_mem[tb_rp_ff], i_parity_odd);
            tx_div_ff <= div - 16'h0001;
            o_tx <= 1'b0; // start bit
            tx_st_ff <= ST_DATA;
            tx_bit_ff <= 4'h0;
          end
        end
        ST_DATA: if (tx_tick) begin
          o_tx <= tx_sh_ff[0]; // lsb first
          tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
          tx_bit_ff <= tx_bit_ff + 4'h1;
          if (tx_bit_ff == `URT_BITS - 4'h1) begin
            tx_st_ff <= i_parity_en ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: if (tx_tick) begin
          o_tx <= tx_par_ff; // ninth bit
          tx_st_ff <= ST_STOP;
        end
        ST_STOP: if (tx_tick) begin
          o_tx <= 1'b1; // stop bit
          tx_st_ff <= ST_START;
        end
        ST_START: if (tx_tick) begin
          tx_st_ff <= ST_IDLE; // stop bit held a full period
        end
        default: tx_st_ff <= ST_IDLE;
      endcase
    end
  end
  // ---- receive engine, samples mid-bit
  urt_state_e rx_st_ff;
  logic [15:0] rx_div_ff;
  logic [3:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_perr_ff, rx_done;
  urt_char_s rx_new;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_st_ff <= ST_IDLE;
      rx_div_ff <= 16'h0000;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_perr_ff <= 1'b0;
      rx_done <= 1'b0;
      rx_new <= '0;
    end else begin
      rx_done <= 1'b0;
      if (rx_st_ff != ST_IDLE) begin
        rx_div_ff <= rx_div_ff - 16'h0001;
      end
      case (rx_st_ff)
        ST_IDLE: if (!rx_s2_ff) begin
          rx_div_ff <= {1'b0, div[15:1]};
          rx_st_ff <= ST_START;
        end
        ST_START: if (rx_div_ff == 16'h0000) begin
          rx_div_ff <= div - 16'h0001;
          rx_bit_ff <= 4'h0;
          rx_perr_ff <= 1'b0;
          // a glitch shorter than half a bit is dropped
          rx_st_ff <= rx_s2_ff ? ST_IDLE : ST_DATA;
        end
        ST_DATA: if (rx_div_ff == 16'h0000) begin
          rx_div_ff <= div - 16'h0001;
          rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
          rx_bit_ff <= rx_bit_ff + 4'h1;
          if (rx_bit_ff == `URT_BITS - 4'h1) begin
            rx_st_ff <= i_parity_en ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: if (rx_div_ff == 16'h0000) begin
          rx_div_ff <= div - 16'h0001;
          rx_perr_ff <= rx_s2_ff
                        != par_of(rx_sh_ff, i_parity_odd);
          rx_st_ff <= ST_STOP;
        end
        ST_STOP: if (rx_div_ff == 16'h0000) begin
          rx_new <= '{data: rx_sh_ff, parity_err: rx_perr_ff,
                      frame_err: ~rx_s2_ff};
          rx_done <= 1'b1;
          rx_st_ff <= ST_IDLE;
        end
        default: rx_st_ff <= ST_IDLE;
      endcase
    end
  end
  // ---- receive buffer, six characters
  urt_char_s rb_mem [0:`URT_RX_DEPTH-1];
  logic [2:0] rb_wp_ff, rb_rp_ff, rb_cnt_ff, nxt_rb_cnt;
  logic rb_push, rb_pop;
  assign rb_push = rx_done && (rb_cnt_ff != 3'(`URT_RX_DEPTH));
  assign rb_pop = (rb_cnt_ff != 3'h0) && (!o_rx_valid || i_rx_ready);
  assign nxt_rb_cnt = rb_cnt_ff + {2'h0, rb_push} - {2'h0, rb_pop};
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rb_wp_ff <= 3'h0;
      rb_rp_ff <= 3'h0;
      rb_cnt_ff <= 3'h0;
    end else begin
      if (rb_push) begin
        rb_mem[rb_wp_ff] <= rx_new;
        rb_wp_ff <= (rb_wp_ff == 3'(`URT_RX_DEPTH - 1)) ? 3'h0
                                                       : rb_wp_ff + 3'h1;
      end
      if (rb_pop) begin
        rb_rp_ff <= (rb_rp_ff == 3'(`URT_RX_DEPTH - 1)) ? 3'h0
                                                       : rb_rp_ff + 3'h1;
      end
      rb_cnt_ff <= nxt_rb_cnt;
    end
  end
  // output register stage toward the user
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_char <= '0;
    end else if (rb_pop) begin
      o_rx_valid <= 1'b1;
      o_rx_char <= rb_mem[rb_rp_ff];
    end else if (i_rx_ready) begin
      o_rx_valid <= 1'b0;
    end
  end
  // request-to-send drops early: the far side may still send a few
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rts_n <= 1'b0; // ready right after reset
    end else begin
      o_rts_n <= (3'(`URT_RX_DEPTH) - nxt_rb_cnt)
                 <= `URT_RTS_MARGIN;
    end
  end
  // checks
  sequence s_idle_cts_off;
    (tx_st_ff == ST_IDLE) && !cts_on;
  endsequence
  a_tx_waits_cts: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_idle_cts_off |=> (tx_st_ff == ST_IDLE) && o_tx)
    else $error("transmit started without clear-to-send");
  a_tx_idle_high: assert property (@(posedge i_mclk) disable iff (i_rst)
    (tx_st_ff == ST_IDLE) && !$past(tx_take) |-> o_tx)
    else $error("transmit line low while idle");
  a_tx_start_low: assert property (@(posedge i_mclk) disable iff (i_rst)
    tx_take |=> !o_tx && (tx_st_ff == ST_DATA))
    else $error("start bit missing");
  a_rts_full: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rb_cnt_ff >= 3'h4) |-> ##1 $past(o_rts_n) || o_rts_n)
    else $error("request-to-send held with buffer nearly full");
  a_rts_empty: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rb_cnt_ff == 3'h0) && !rx_done |=> !o_rts_n)
    else $error("request-to-send withdrawn with empty buffer");
  a_rb_bound: assert property (@(posedge i_mclk) disable iff (i_rst)
    rb_cnt_ff <= 3'(`URT_RX_DEPTH))
    else $error("receive buffer count beyond depth");
  a_pads_fixed: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_rx_pullup && o_cts_pulldown)
    else $error("pad pull controls dropped");
  a_parity_slot: assert property (@(posedge i_mclk) disable iff (i_rst)
    (tx_st_ff == ST_PAR) && tx_tick |=> o_tx == $past(tx_par_ff))
    else $error("parity bit wrong");
  a_rate_cap: assert property (@(posedge i_mclk) disable iff (i_rst)
    div >= 16'(`URT_MIN_DIV))
    else $error("bit period below top rate");

endmodule : urt_core

/* File: verif/urt_host_model.sv */
`timescale 1ns/1ps
// far-side serial host: drives our receive pin, listens on our transmit
module urt_host_model (
  // clock and character format
  input wire logic i_mclk,
  input wire logic i_par_en,
  input wire logic i_par_odd,
  // serial pins seen from the device
  input wire logic i_dev_tx,
  input wire logic i_rts_n,
  output logic o_dev_rx,
  output logic o_cts_n
);
  localparam int DIV = 25;
  logic ignore_rts;
  logic [9:0] rxq[$];
  // lines rest idle; clear-to-send asserted at 0 V
  initial begin
    o_dev_rx = 1'b1;
    o_cts_n = 1'b0;
    ignore_rts = 1'b0;
  end
  // one frame, lsb first; faults only when the caller asks for them
  task automatic send_char(input logic [7:0] d, input logic bad_par,
                           input logic bad_stop);
    logic [10:0] f;
    while (i_rts_n !== 1'b0 && !ignore_rts) @(negedge i_mclk);
    f = {~bad_stop, (^d) ^ i_par_odd ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || i_par_en) begin
        o_dev_rx = f[i];
        repeat (DIV) @(negedge i_mclk);
      end
    end
    o_dev_rx = 1'b1;
    repeat (DIV) @(negedge i_mclk);
  endtask : send_char
  // mid-bit sampling keeps a small clock offset harmless
  initial begin
    logic [9:0] r;
    forever begin
      @(negedge i_dev_tx);
      r = '0;
      repeat (DIV / 2) @(posedge i_mclk);
      for (int i = 0; i < 10; i++) begin
        if (i != 8 || i_par_en) begin
          repeat (DIV) @(posedge i_mclk);
          r[i] = i_dev_tx;
        end
      end
      rxq.push_back(r);
    end
  end
endmodule : urt_host_model

/* File: verif/urt_core_tb.sv */
`timescale 1ns/1ps
// self-checking bench, host model across the serial pins
module urt_core_tb;
  import urt_pkg::*;
  logic i_mclk, i_rst, par_en, par_odd, tx_valid, rx_ready;
  logic tx, rx, rts_n, cts_n, rx_valid, tx_ready, pull_up, pull_dn;
  logic [7:0] tx_data;
  logic [15:0] baud_div;
  urt_char_s rx_char;
  int err_total, n_checks;
  // rows: {parity bit on wire, odd, enable, data}
  logic [10:0] rows [5] = '{11'h055, 11'h1a3, 11'h700, 11'h1ff, 11'h380};
  // divider at the 1 Mbps floor keeps frames short
  urt_core i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_baud_div(baud_div),
    .i_parity_en(par_en), .i_parity_odd(par_odd), .i_rx(rx), .o_tx(tx),
    .o_rx_pullup(pull_up), .i_cts_n(cts_n), .o_cts_pulldown(pull_dn),
    .o_rts_n(rts_n), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_char(rx_char),
    .i_rx_ready(rx_ready));
  urt_host_model i_host (.i_mclk(i_mclk), .i_par_en(par_en),
    .i_par_odd(par_odd), .i_dev_tx(tx), .i_rts_n(rts_n), .o_dev_rx(rx),
    .o_cts_n(cts_n));
  // 25 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // called at a falling edge; valid stays up so pushes run back to back
  task automatic push(input logic [7:0] d);
    tx_valid = 1'b1;
    tx_data = d;
    while (tx_ready !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
  endtask : push
  task automatic drain(input logic [9:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 2000) begin
      @(negedge i_mclk);
      n++;
    end
    check(16'({rx_valid, rx_char}), 16'({1'b1, exp}));
    rx_ready = 1'b1;
    @(negedge i_mclk);
    rx_ready = 1'b0;
    // let an edge pass so a following call does not re-raise ready at once
    @(negedge i_mclk);
  endtask : drain
  task automatic host_get(input logic [9:0] exp);
    logic [9:0] got;
    int n;
    n = 0;
    while (i_host.rxq.size() == 0 && n < 4000) begin
      @(negedge i_mclk);
      n++;
    end
    got = (i_host.rxq.size() > 0) ? i_host.rxq.pop_front() : 'x;
    check(16'(got), 16'(exp));
  endtask : host_get
  // main sequence
  initial begin
    logic lo;
    i_rst = 1'b1;
    par_en = 1'b0;
    par_odd = 1'b0;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    tx_data = 8'h00;
    baud_div = 16'h0019;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(negedge i_mclk);
    i_rst = 1'b0;
    @(negedge i_mclk);
    check({tx, rts_n, tx_ready, rx_valid}, 16'h000a);
    check({pull_up, pull_dn}, 16'h0003);
    $display("test reset done");
    foreach (rows[k]) begin
      par_en = rows[k][8];
      par_odd = rows[k][9];
      fork
        i_host.send_char(rows[k][7:0], 1'b0, 1'b0);
        begin
          push(rows[k][7:0]);
          tx_valid = 1'b0;
        end
      join
      drain({rows[k][7:0], 2'b00});
      host_get({1'b1, rows[k][10], rows[k][7:0]});
    end
    $display("test rows done");
    par_en = 1'b0;
    // divider below the floor: the host still decodes at the top rate
    baud_div = 16'h0004;
    fork
      begin
        push(8'h11);
        push(8'h22);
        tx_valid = 1'b0;
      end
      begin
        @(negedge tx);
        @(negedge i_mclk);
        i_host.o_cts_n = 1'b1;
      end
    join
    host_get(10'h211);
    lo = 1'b0;
    repeat (400) begin
      @(negedge i_mclk);
      lo = lo | ~tx;
    end
    check(lo, 1'b0);
    i_host.o_cts_n = 1'b0;
    host_get(10'h222);
    $display("test flow done");
    par_en = 1'b1;
    i_host.send_char(8'h5a, 1'b1, 1'b0);
    drain({8'h5a, 2'b10});
    i_host.send_char(8'h5a, 1'b0, 1'b1);
    drain({8'h5a, 2'b01});
    $display("test errors done");
    par_en = 1'b0;
    i_host.ignore_rts = 1'b1;
    // six in the buffer plus one in the output stage; the eighth is lost
    for (int i = 0; i < 8; i++) begin
      i_host.send_char(8'h40 + 8'(i), 1'b0, 1'b0);
      if (i == 3) check(rts_n, 1'b0);
      if (i == 4) check(rts_n, 1'b1);
    end
    i_host.ignore_rts = 1'b0;
    for (int i = 0; i < 7; i++) drain({8'h40 + 8'(i), 2'b00});
    @(negedge i_mclk);
    check({rx_valid, rts_n}, 16'h0000);
    $display("test buffer done");
    // reset in mid-frame with a character waiting at the output
    i_host.send_char(8'h77, 1'b0, 1'b0);
    push(8'h33);
    tx_valid = 1'b0;
    repeat (85) @(negedge i_mclk);
    check({tx, rx_valid}, 16'h0001);
    i_rst = 1'b1;
    @(negedge i_mclk);
    check({tx, rts_n, tx_ready, rx_valid}, 16'h000a);
    i_rst = 1'b0;
    @(negedge i_mclk);
    @(negedge i_mclk);
    check({tx, rts_n, tx_ready, rx_valid}, 16'h000a);
    $display("test reset again done");
    finish_test();
  end
  // all frames need under 10000 clocks; a stuck handshake ends here
  initial begin
    repeat (40000) @(posedge i_mclk);
    err_total++;
    finish_test();
  end
endmodule : urt_core_tb
